// file: hdl/i2csl_bus_if.sv
// open-drain scl/sda bus joining the host controller and the slave port
`timescale 1ns/1ps
interface i2csl_bus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

// file: hdl/i2csl_device.sv
// i2c slave host port: strap address, burst register access, high_speed_mode
//
// Function
// - receiver acks each byte, transmitter releases sda
// - master nack on read: slave releases sda
// - after ack master sends stop or restart
// - first byte after start is address plus direction
// - strap and address pins latched once after reset
// - strap low: address 0101b plus three pins
// - strap high: six pins, bit six zero
// - write frame: register byte, data, same register
// - read needs prior write of register byte
// - read frame returns same register every byte
// - hs entry: start, master code, nack
// - hs kept across restarts until stop
// - fast after reset, hs on code, fast on stop
// - hs changes input filters and sda slope
// - force bit keeps high_speed_mode permanently
// - without master code stay fast/standard
// - slave only, never drives scl
// - start/stop while scl high, data changes scl low
// - bytes msb first, each followed by ack
`timescale 1ns/1ps
module i2csl_device import i2csl_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  i2csl_bus_if.dev bus,
  input wire logic i_address_mode_strap,
  input wire logic [5:0] i_addr_pins,
  input wire logic i_force_high_speed_bit,
  input wire logic [7:0] i_reg_rdata,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic o_high_speed_mode,
  output logic o_input_filter_hs,
  output logic o_sda_slope_hs,
  output logic o_selected
);
  logic scl_s1;
  logic scl_s2;
  logic sda_s1;
  logic sda_s2;
  logic strap_s1;
  logic strap_s2;
  logic [5:0] pins_s1;
  logic [5:0] pins_s2;
  logic strap_done;
  logic next_strap_done;
  logic [6:0] own_addr;
  logic [6:0] next_own_addr;
  logic [1:0] raw;
  logic [1:0] filt;
  logic [1:0] prev;
  logic [1:0] lim;
  logic scl_f;
  logic sda_f;
  logic start;
  logic stop;
  logic scl_rise;
  logic scl_fall;
  i2csl_dev_state_t st;
  i2csl_dev_state_t next_st;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] sr;
  logic [7:0] next_sr;
  logic have_reg;
  logic next_have_reg;
  logic rd_mode;
  logic next_rd_mode;
  logic rd_pend;
  logic sda_oe;
  logic next_sda_oe;
  logic hs;
  logic next_hs;
  logic [7:0] next_reg_addr;
  logic [7:0] next_reg_wdata;
  logic next_reg_wr;
  logic next_reg_rd;
  logic next_selected;

  // output stage only ever pulls low
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe;

  // pin synchronisers
  always_ff @(posedge i_sys_clk) begin
    scl_s1 <= bus.scl;
    scl_s2 <= scl_s1;
    sda_s1 <= bus.sda;
    sda_s2 <= sda_s1;
    strap_s1 <= i_address_mode_strap;
    strap_s2 <= strap_s1;
    pins_s1 <= i_addr_pins;
    pins_s2 <= pins_s1;
  end

  // address capture at the first cycle after reset release
  always_comb begin
    next_strap_done = 1'b1;
    next_own_addr = own_addr;
    if (!strap_done) begin
      if (strap_s2) begin
        next_own_addr = {1'b0, pins_s2};
      end else begin
        next_own_addr = {I2CSL_FIXED_UPPER, pins_s2[2:0]};
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      strap_done <= 1'b0;
      own_addr <= 7'h00;
    end else begin
      strap_done <= next_strap_done;
      own_addr <= next_own_addr;
    end
  end

  // spike filters, length set by speed mode
  assign raw = {sda_s2, scl_s2};
  assign lim = hs ? I2CSL_FILT_HS_LEN : I2CSL_FILT_FS_LEN;

  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [1:0] fcnt;
    logic [1:0] next_fcnt;
    logic next_filt;
    always_comb begin
      next_filt = filt[g];
      next_fcnt = 2'h0;
      if (raw[g] != filt[g]) begin
        if (fcnt >= 2'(lim - 2'h1)) begin
          next_filt = raw[g];
        end else begin
          next_fcnt = 2'(fcnt + 2'h1);
        end
      end
    end
    always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
        fcnt <= 2'h0;
        filt[g] <= I2CSL_FILT_IDLE[g];
        prev[g] <= I2CSL_FILT_IDLE[g];
      end else begin
        fcnt <= next_fcnt;
        filt[g] <= next_filt;
        prev[g] <= filt[g];
      end
    end
  end

  assign scl_f = filt[0];
  assign sda_f = filt[1];
  assign start = scl_f & prev[0] & prev[1] & ~sda_f;
  assign stop = scl_f & prev[0] & ~prev[1] & sda_f;
  assign scl_rise = scl_f & ~prev[0];
  assign scl_fall = ~scl_f & prev[0];

  // protocol engine
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sr = sr;
    next_have_reg = have_reg;
    next_rd_mode = rd_mode;
    next_sda_oe = sda_oe;
    next_hs = hs | i_force_high_speed_bit;
    next_reg_addr = o_reg_addr;
    next_reg_wdata = o_reg_wdata;
    next_reg_wr = 1'b0;
    next_reg_rd = 1'b0;
    next_selected = o_selected;
    if (rd_pend) begin
      next_sr = i_reg_rdata;
    end
    if (start) begin
      next_st = I2CSL_D_ADDR;
      next_cnt = 4'h0;
      next_sda_oe = 1'b0;
      next_have_reg = 1'b0;
      next_selected = 1'b0;
    end else if (stop) begin
      next_st = I2CSL_D_IDLE;
      next_sda_oe = 1'b0;
      next_selected = 1'b0;
      next_hs = i_force_high_speed_bit;
    end else begin
      unique case (st)
        I2CSL_D_IDLE, I2CSL_D_SKIP: begin
          next_sda_oe = 1'b0;
        end
        I2CSL_D_ADDR, I2CSL_D_RX: begin
          if (scl_rise) begin
            next_sr = {sr[6:0], sda_f};
            next_cnt = 4'(cnt + 4'h1);
          end else if (scl_fall && cnt == I2CSL_BITS_PER_BYTE) begin
            if (st == I2CSL_D_RX) begin
              next_sda_oe = 1'b1;
              next_st = I2CSL_D_ACK;
              if (have_reg) begin
                next_reg_wdata = sr;
                next_reg_wr = 1'b1;
              end else begin
                next_reg_addr = sr;
                next_have_reg = 1'b1;
              end
            end else if (sr[7:3] == I2CSL_MCODE_PREFIX) begin
              next_st = I2CSL_D_MCODE;
            end else if (sr[7:1] == own_addr) begin
              next_sda_oe = 1'b1;
              next_selected = 1'b1;
              next_rd_mode = sr[0];
              next_reg_rd = sr[0];
              next_st = I2CSL_D_ACK;
            end else begin
              next_st = I2CSL_D_SKIP;
            end
          end
        end
        I2CSL_D_MCODE: begin
          if (scl_rise) begin
            if (sda_f) begin
              next_hs = 1'b1;
            end
            next_st = I2CSL_D_SKIP;
          end
        end
        I2CSL_D_ACK: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (rd_mode) begin
              next_sda_oe = ~sr[7];
              next_st = I2CSL_D_TX;
            end else begin
              next_sda_oe = 1'b0;
              next_st = I2CSL_D_RX;
            end
          end
        end
        I2CSL_D_TX: begin
          if (scl_rise) begin
            next_cnt = 4'(cnt + 4'h1);
          end else if (scl_fall) begin
            if (cnt == I2CSL_BITS_PER_BYTE) begin
              next_sda_oe = 1'b0;
              next_st = I2CSL_D_TACK;
            end else begin
              next_sr = {sr[6:0], 1'b0};
              next_sda_oe = ~sr[6];
            end
          end
        end
        I2CSL_D_TACK: begin
          if (scl_rise) begin
            if (sda_f) begin
              next_st = I2CSL_D_SKIP;
              next_selected = 1'b0;
            end else begin
              next_reg_rd = 1'b1;
              next_st = I2CSL_D_TNEXT;
            end
          end
        end
        I2CSL_D_TNEXT: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            next_sda_oe = ~sr[7];
            next_st = I2CSL_D_TX;
          end
        end
        default: begin
          next_st = I2CSL_D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st <= I2CSL_D_IDLE;
      cnt <= 4'h0;
      sr <= 8'h00;
      have_reg <= 1'b0;
      rd_mode <= 1'b0;
      rd_pend <= 1'b0;
      sda_oe <= 1'b0;
      hs <= 1'b0;
      o_reg_addr <= 8'h00;
      o_reg_wdata <= 8'h00;
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      o_high_speed_mode <= 1'b0;
      o_input_filter_hs <= 1'b0;
      o_sda_slope_hs <= 1'b0;
      o_selected <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      sr <= next_sr;
      have_reg <= next_have_reg;
      rd_mode <= next_rd_mode;
      rd_pend <= o_reg_rd;
      sda_oe <= next_sda_oe;
      hs <= next_hs;
      o_reg_addr <= next_reg_addr;
      o_reg_wdata <= next_reg_wdata;
      o_reg_wr <= next_reg_wr;
      o_reg_rd <= next_reg_rd;
      o_high_speed_mode <= next_hs;
      o_input_filter_hs <= next_hs;
      o_sda_slope_hs <= next_hs;
      o_selected <= next_selected;
    end
  end
endmodule

// file: hdl/i2csl_host.sv
// i2c bus master driven by byte commands through a small register port
`timescale 1ns/1ps
module i2csl_host import i2csl_pkg::*; #(
  parameter int QTR = I2CSL_SCL_QTR
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  i2csl_bus_if.host bus,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata
);
  logic sda_s1;
  logic sda_s2;
  i2csl_host_state_t st;
  i2csl_host_state_t next_st;
  logic [7:0] tcnt;
  logic [7:0] next_tcnt;
  logic [1:0] q;
  logic [1:0] next_q;
  logic [3:0] bitn;
  logic [3:0] next_bitn;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [7:0] txd;
  logic [7:0] next_txd;
  logic [7:0] rxd;
  logic [7:0] next_rxd;
  logic rd_mode;
  logic next_rd_mode;
  logic nack;
  logic next_nack;
  logic ack;
  logic next_ack;
  logic scl_oe;
  logic next_scl_oe;
  logic sda_oe;
  logic next_sda_oe;
  logic [7:0] next_rdata;
  logic tick;

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_oe = sda_oe;
  assign tick = (tcnt == 8'(QTR - 1));

  always_ff @(posedge i_sys_clk) begin
    sda_s1 <= bus.sda;
    sda_s2 <= sda_s1;
  end

  always_comb begin
    next_st = st;
    next_tcnt = tick ? 8'h00 : 8'(tcnt + 8'h01);
    next_q = q;
    next_bitn = bitn;
    next_sh = sh;
    next_txd = txd;
    next_rxd = rxd;
    next_rd_mode = rd_mode;
    next_nack = nack;
    next_ack = ack;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        I2CSL_REG_TXDATA: next_rdata = txd;
        I2CSL_REG_RXDATA: next_rdata = rxd;
        I2CSL_REG_STATUS: next_rdata = {6'h00, ack, st != I2CSL_H_IDLE};
        default: next_rdata = 8'h00;
      endcase
    end
    if (i_wr && i_addr == I2CSL_REG_TXDATA) begin
      next_txd = i_wdata;
    end
    if (st == I2CSL_H_IDLE) begin
      next_tcnt = 8'h00;
      next_q = 2'h0;
      next_bitn = 4'h0;
      if (i_wr && i_addr == I2CSL_REG_CTRL) begin
        if (i_wdata[I2CSL_CTRL_START]) begin
          next_st = I2CSL_H_START;
        end else if (i_wdata[I2CSL_CTRL_STOP]) begin
          next_st = I2CSL_H_STOP;
        end else if (i_wdata[I2CSL_CTRL_WRITE]) begin
          next_st = I2CSL_H_BYTE;
          next_rd_mode = 1'b0;
          next_sh = txd;
        end else if (i_wdata[I2CSL_CTRL_READ]) begin
          next_st = I2CSL_H_BYTE;
          next_rd_mode = 1'b1;
          next_nack = i_wdata[I2CSL_CTRL_NACK];
        end
      end
    end else if (tick) begin
      next_q = 2'(q + 2'h1);
      unique case (st)
        I2CSL_H_START: begin
          // sda released with scl as the last command left it, then falls while scl high
          unique case (q)
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b1;
            2'h3: begin
              next_scl_oe = 1'b1;
              next_st = I2CSL_H_IDLE;
            end
          endcase
        end
        I2CSL_H_STOP: begin
          unique case (q)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0;
            2'h3: next_st = I2CSL_H_IDLE;
          endcase
        end
        I2CSL_H_BYTE: begin
          unique case (q)
            2'h0: begin
              if (bitn < I2CSL_BITS_PER_BYTE) begin
                next_sda_oe = ~rd_mode & ~sh[7];
              end else begin
                next_sda_oe = rd_mode & ~nack;
              end
            end
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              if (bitn < I2CSL_BITS_PER_BYTE) begin
                next_sh = {sh[6:0], sda_s2};
              end else if (!rd_mode) begin
                next_ack = ~sda_s2;
              end
            end
            2'h3: begin
              next_scl_oe = 1'b1;
              if (bitn == I2CSL_BITS_PER_BYTE) begin
                next_rxd = sh;
                next_st = I2CSL_H_IDLE;
              end else begin
                next_bitn = 4'(bitn + 4'h1);
              end
            end
          endcase
        end
        default: next_st = I2CSL_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st <= I2CSL_H_IDLE;
      tcnt <= 8'h00;
      q <= 2'h0;
      bitn <= 4'h0;
      sh <= 8'h00;
      txd <= 8'h00;
      rxd <= 8'h00;
      rd_mode <= 1'b0;
      nack <= 1'b0;
      ack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      st <= next_st;
      tcnt <= next_tcnt;
      q <= next_q;
      bitn <= next_bitn;
      sh <= next_sh;
      txd <= next_txd;
      rxd <= next_rxd;
      rd_mode <= next_rd_mode;
      nack <= next_nack;
      ack <= next_ack;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      o_rdata <= next_rdata;
    end
  end
endmodule

// file: hdl/i2csl_pkg.sv
// shared constants and types for the i2c slave host port and its master
package i2csl_pkg;
  localparam logic [3:0] I2CSL_FIXED_UPPER = 4'h5;
  localparam logic [4:0] I2CSL_MCODE_PREFIX = 5'h01;
  localparam logic [3:0] I2CSL_BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] I2CSL_FILT_FS_LEN = 2'h3;
  localparam logic [1:0] I2CSL_FILT_HS_LEN = 2'h1;
  localparam logic [1:0] I2CSL_FILT_IDLE = 2'h3;
  localparam int I2CSL_SCL_QTR = 8;
  localparam logic [3:0] I2CSL_REG_CTRL = 4'h0;
  localparam logic [3:0] I2CSL_REG_TXDATA = 4'h1;
  localparam logic [3:0] I2CSL_REG_RXDATA = 4'h2;
  localparam logic [3:0] I2CSL_REG_STATUS = 4'h3;
  localparam int I2CSL_CTRL_START = 0;
  localparam int I2CSL_CTRL_STOP = 1;
  localparam int I2CSL_CTRL_WRITE = 2;
  localparam int I2CSL_CTRL_READ = 3;
  localparam int I2CSL_CTRL_NACK = 4;
  localparam int I2CSL_STAT_BUSY = 0;
  localparam int I2CSL_STAT_ACK = 1;
  typedef enum logic [3:0] {
    I2CSL_D_IDLE, I2CSL_D_ADDR, I2CSL_D_RX, I2CSL_D_MCODE, I2CSL_D_ACK,
    I2CSL_D_TX, I2CSL_D_TACK, I2CSL_D_TNEXT, I2CSL_D_SKIP
  } i2csl_dev_state_t;
  typedef enum logic [1:0] {
    I2CSL_H_IDLE, I2CSL_H_START, I2CSL_H_BYTE, I2CSL_H_STOP
  } i2csl_host_state_t;
endpackage

// file: verif/i2csl_bus_properties.sv
// checker for the scl/sda link between host controller and slave port
`timescale 1ns/1ps
module i2csl_bus_properties import i2csl_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, first, rd_dir, idle;
  logic next_first, next_rd_dir, next_idle;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  wire rise = scl && !scl_q;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  wire ninth = rise && (cnt == 4'h8);
  always_comb begin
    next_cnt = cnt;
    next_first = first;
    next_rd_dir = rd_dir;
    next_sh = sh;
    next_idle = idle || stop;
    if (start) begin
      next_cnt = 4'h0;
      next_first = 1'b1;
      next_idle = 1'b0;
    end else if (rise) begin
      next_sh = {sh[6:0], sda};
      next_cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h8) next_first = 1'b0;
      if (first && cnt == 4'h7) next_rd_dir = sda;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt <= 4'h0;
      first <= 1'b1;
      rd_dir <= 1'b0;
      sh <= 8'h00;
      idle <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      cnt <= next_cnt;
      first <= next_first;
      rd_dir <= next_rd_dir;
      sh <= next_sh;
      idle <= next_idle;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  a_scl_host_only: assert property (scl != host_scl_oe)
    else $error("scl level not set by host alone");
  a_open_drain: assert property ((dev_sda_oe |-> !dev_sda_o) and
    (host_sda_oe |-> !host_sda_o) and (host_scl_oe |-> !host_scl_o))
    else $error("bus line driven high");
  a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("slave sda changed while scl high");
  a_ack_stable: assert property (ninth && dev_sda_oe |-> dev_sda_oe throughout scl[*8])
    else $error("slave ack not stable in high phase");
  a_read_ack_free: assert property (ninth && !first && rd_dir |-> !dev_sda_oe)
    else $error("slave drives sda in master ack slot");
  a_nack_release: assert property (ninth && !first && rd_dir && sda |->
    ##20 (!dev_sda_oe)[*8])
    else $error("slave drives sda after master nack");
  a_mcode_no_ack: assert property (ninth && first &&
    sh[7:3] == I2CSL_MCODE_PREFIX |-> !dev_sda_oe)
    else $error("master code acknowledged");
  a_idle_released: assert property (idle |-> !dev_sda_oe)
    else $error("slave drives sda on idle bus");
  a_drive_holds: assert property ($rose(dev_sda_oe) |=> dev_sda_oe[*8])
    else $error("slave sda low pulse too short");
  c_slave_ack: cover property (ninth && dev_sda_oe);
  c_master_nack: cover property (ninth && !first && rd_dir && sda);
  c_stop: cover property (stop);
endmodule

// file: verif/i2csl_device_tb.sv
// self-checking bench for host controller and slave port joined on one bus
`timescale 1ns/1ps
module i2csl_device_tb;
  import i2csl_pkg::*;
  logic i_sys_clk, i_srst, strap, force_hs, host_wr, host_rd, reg_wr, reg_rd, sel;
  logic hs, filt_hs, slope_hs;
  logic [5:0] pins;
  logic [3:0] host_addr;
  logic [7:0] host_wdata, o_rdata, reg_rdata, reg_addr, reg_wdata, pops;
  logic [15:0] wq[$];
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  i2csl_bus_if i2csl_bus_if_i ();
  i2csl_host i2csl_host_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .bus(i2csl_bus_if_i),
    .i_addr(host_addr), .i_wdata(host_wdata), .i_wr(host_wr), .i_rd(host_rd), .o_rdata(o_rdata));
  i2csl_device i2csl_device_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .bus(i2csl_bus_if_i),
    .i_address_mode_strap(strap), .i_addr_pins(pins), .i_force_high_speed_bit(force_hs),
    .i_reg_rdata(reg_rdata), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .o_high_speed_mode(hs), .o_input_filter_hs(filt_hs),
    .o_sda_slope_hs(slope_hs), .o_selected(sel));
  i2csl_bus_properties i2csl_bus_properties_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .host_scl_o(i2csl_bus_if_i.host_scl_o), .host_scl_oe(i2csl_bus_if_i.host_scl_oe),
    .host_sda_o(i2csl_bus_if_i.host_sda_o), .host_sda_oe(i2csl_bus_if_i.host_sda_oe),
    .dev_sda_o(i2csl_bus_if_i.dev_sda_o), .dev_sda_oe(i2csl_bus_if_i.dev_sda_oe),
    .scl(i2csl_bus_if_i.scl), .sda(i2csl_bus_if_i.sda));
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // register file stand-in: reads pop a counter, writes are logged
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (i_srst) begin
      reg_rdata <= 8'h00;
      pops <= 8'h00;
      wq.delete();
    end else begin
      if (reg_rd) begin
        reg_rdata <= reg_addr + pops;
        pops <= pops + 8'h01;
      end
      if (reg_wr) wq.push_back({reg_addr, reg_wdata});
    end
    if (cycles == 60000) begin
      err_count++;
      complete_run();
    end
  end
  task complete_run();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge i_sys_clk);
    host_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge i_sys_clk);
    host_rd <= 1'b0;
    @(negedge i_sys_clk);
    d = o_rdata;
  endtask
  task cmd(input logic [7:0] c);
    logic [7:0] s;
    wr(I2CSL_REG_CTRL, c);
    s = 8'h01;
    for (int n = 0; n < 400 && s[I2CSL_STAT_BUSY]; n++) rd(I2CSL_REG_STATUS, s);
    chk(s & 8'h01, 8'h00);
  endtask
  task send(input logic [7:0] b, input logic ack);
    logic [7:0] s;
    wr(I2CSL_REG_TXDATA, b);
    cmd(8'h01 << I2CSL_CTRL_WRITE);
    rd(I2CSL_REG_STATUS, s);
    chk({7'h00, s[I2CSL_STAT_ACK]}, {7'h00, ack});
  endtask
  task recv(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    cmd((8'h01 << I2CSL_CTRL_READ) | (last ? (8'h01 << I2CSL_CTRL_NACK) : 8'h00));
    rd(I2CSL_REG_RXDATA, d);
    chk(d, exp);
  endtask
  task bus_start();
    cmd(8'h01 << I2CSL_CTRL_START);
  endtask
  task bus_stop();
    cmd(8'h01 << I2CSL_CTRL_STOP);
  endtask
  task reset_dut(input logic s, input logic [5:0] p);
    @(posedge i_sys_clk);
    strap <= s;
    pins <= p;
    i_srst <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    pins <= ~p;
  endtask
  task t_write_burst();
    reset_dut(1'b0, 6'h05);
    bus_start();
    send(8'h5a, 1'b1);
    chk({7'h00, sel}, 8'h01);
    send(8'h12, 1'b1);
    for (int k = 0; k < 3; k++) send(8'ha0 + 8'(k), 1'b1);
    bus_stop();
    chk({7'h00, sel}, 8'h00);
    chk(8'(wq.size()), 8'h03);
    for (int k = 0; k < 3; k++) chk(wq[k][15:8], 8'h12);
    for (int k = 0; k < 3; k++) chk(wq[k][7:0], 8'ha0 + 8'(k));
    chk({5'h00, hs, filt_hs, slope_hs}, 8'h00);
    bus_start();
    send(8'h5c, 1'b0);
    send(8'h77, 1'b0);
    bus_stop();
    chk(8'(wq.size()), 8'h03);
  endtask
  task t_read_burst();
    bus_start();
    send(8'h5a, 1'b1);
    send(8'h07, 1'b1);
    bus_stop();
    bus_start();
    send(8'h5b, 1'b1);
    recv(1'b0, 8'h07);
    recv(1'b0, 8'h08);
    recv(1'b1, 8'h09);
    bus_stop();
    chk(reg_addr, 8'h07);
    chk(pops, 8'h03);
  endtask
  task t_high_speed();
    for (int k = 0; k < 8; k++) begin
      bus_start();
      send(8'h08 + 8'(k), 1'b0);
      chk({5'h00, hs, filt_hs, slope_hs}, 8'h07);
      bus_stop();
      chk({5'h00, hs, filt_hs, slope_hs}, 8'h00);
    end
    bus_start();
    send(8'h0f, 1'b0);
    bus_start();
    send(8'h5a, 1'b1);
    send(8'h12, 1'b1);
    bus_start();
    send(8'h5a, 1'b1);
    chk({7'h00, hs}, 8'h01);
    bus_stop();
    chk({7'h00, hs}, 8'h00);
  endtask
  task t_force_hs();
    @(posedge i_sys_clk);
    force_hs <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk({5'h00, hs, filt_hs, slope_hs}, 8'h07);
    bus_start();
    send(8'h5a, 1'b1);
    bus_stop();
    chk({7'h00, hs}, 8'h01);
    @(posedge i_sys_clk);
    force_hs <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    chk({7'h00, hs}, 8'h01);
    bus_start();
    bus_stop();
    chk({7'h00, hs}, 8'h00);
  endtask
  task t_strap_high();
    reset_dut(1'b1, 6'h2a);
    bus_start();
    send(8'h54, 1'b1);
    send(8'h21, 1'b1);
    send(8'hc3, 1'b1);
    bus_stop();
    chk(8'(wq.size()), 8'h01);
    chk(wq[0][15:8], 8'h21);
    chk(wq[0][7:0], 8'hc3);
    bus_start();
    send(8'hd4, 1'b0);
    bus_start();
    send(8'h2a, 1'b0);
    bus_stop();
  endtask
  initial begin
    i_srst = 1'b1;
    strap = 1'b0;
    pins = 6'h00;
    force_hs = 1'b0;
    host_addr = 4'h0;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    t_write_burst();
    t_read_burst();
    t_high_speed();
    t_force_hs();
    t_strap_high();
    complete_run();
  end
endmodule
